// *** core/opl_reader.sv ***
/*
 Reader end of the operator panel and interlock logic: pushbutton
 conditioning, journal option, power gating, interlock bypass, latched
 failure lamps, sync probe selection and timing freeze.
 Assumes panel switches are asynchronous; the controller end is on clk.
*/
`timescale 1ns/1ps
// Overview of operation
// - Held stop button drives stop request high
// - Controller lights stop lamp on not-ready
// - Stop lamp equals reader not ready
// - Parameter button enables controller parameters-only state
// - Parameter lamps lit only pressed and holding
// - Journal button toggles option; lamps show it
// - Power button works only with both enables
// - Power lamps: power on, supplies good
// - Bypasses count only in maintenance mode
// - Each set bypass lights its indicator
// - Normal mode interlock failure drops power
// - Failure lamps latch while power enable on
// - Maintenance bypass masks its fault sensor
// - Sync probes carry controller-selected signals
// - Control position lets software freeze phases
module opl_reader
    import opl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Controller link
    opl_link_if.reader link,
    // Panel pushbuttons
    input wire logic [PB_N-1:0] button_raw,
    // Panel switches
    input wire logic power_enable_sw,
    input wire logic controller_power_sw,
    input wire logic maintenance_sw,
    input wire logic fault_reset_sw,
    input wire logic timing_freeze_position,
    input wire logic [RDR_ILK_N-1:0] rdr_bypass_sw,
    input wire logic [CTL_ILK_N-1:0] ctl_bypass_sw,
    // Sensors
    input wire logic [RDR_ILK_N-1:0] rdr_fault_raw,
    input wire logic [CTL_ILK_N-1:0] ctl_fault_raw,
    input wire logic [DC_N-1:0] dc_ok_raw,
    input wire logic [SYNC_SRC_N-1:0] sync_src,
    // Lamps and controls
    output logic journal_lamp,
    output logic journal_enable,
    output logic reader_ac_on,
    output logic reader_power_lamp,
    output logic system_power_on,
    output logic [RDR_ILK_N-1:0] rdr_bypass_lamp,
    output logic [CTL_ILK_N-1:0] ctl_bypass_lamp,
    output logic [RDR_ILK_N-1:0] rdr_fail_lamp,
    output logic [CTL_ILK_N-1:0] ctl_fail_lamp,
    output logic [1:0] selectable_sync_probe,
    output logic [PHASE_N-1:0] phase_freeze
);
    localparam int SW_N = 5 + RDR_ILK_N + CTL_ILK_N;
    localparam int IN_N = PB_N + SW_N + RDR_ILK_N + CTL_ILK_N + DC_N;

    typedef struct packed {
        logic [IN_N-1:0] s1;
        logic [IN_N-1:0] s2;
        logic [IN_N-1:0] s3;
        logic [IN_N-1:0] in_q;
        logic [PB_N-1:0] pb_stable;
        logic [PB_N-1:0][DB_W-1:0] pb_cnt;
        logic journal_on;
        opl_pwr_t pwr;
        logic [RDR_ILK_N-1:0] rdr_fail;
        logic [CTL_ILK_N-1:0] ctl_fail;
        logic [1:0] probe;
        logic [PHASE_N-1:0] freeze;
        logic stop_out;
        logic param_out;
    } opl_rdr_state_t;

    opl_rdr_state_t state_reg;
    opl_rdr_state_t state_next;
    logic [IN_N-1:0] raw_in;
    logic [PB_N-1:0] pb_in;
    logic [PB_N-1:0] pb_rise;
    logic pwr_en;
    logic ctl_pwr;
    logic maint;
    logic freeze_pos;
    logic [RDR_ILK_N-1:0] rbyp;
    logic [CTL_ILK_N-1:0] cbyp;
    logic [RDR_ILK_N-1:0] rfault;
    logic [CTL_ILK_N-1:0] cfault;
    logic [DC_N-1:0] dc_ok;
    logic any_fault;

    // Mask sensors by bypass, only while in maintenance
    function automatic logic [RDR_ILK_N-1:0] mask_fault(
        input logic [RDR_ILK_N-1:0] sense,
        input logic [RDR_ILK_N-1:0] byp,
        input logic mnt
    );
        mask_fault = sense & ~(byp & {RDR_ILK_N{mnt}});
    endfunction

    assign raw_in = {dc_ok_raw, ctl_fault_raw, rdr_fault_raw, ctl_bypass_sw,
        rdr_bypass_sw, timing_freeze_position, fault_reset_sw, maintenance_sw,
        controller_power_sw, power_enable_sw, button_raw};

    // Field split of the agreed input vector
    assign pb_in = state_reg.in_q[PB_N-1:0];
    assign pwr_en = state_reg.in_q[PB_N];
    assign ctl_pwr = state_reg.in_q[PB_N+1];
    assign maint = state_reg.in_q[PB_N+2];
    assign freeze_pos = state_reg.in_q[PB_N+4];
    assign rbyp = state_reg.in_q[PB_N+5 +: RDR_ILK_N];
    assign cbyp = state_reg.in_q[PB_N+5+RDR_ILK_N +: CTL_ILK_N];
    assign rfault = mask_fault(state_reg.in_q[PB_N+SW_N +: RDR_ILK_N],
        rbyp, maint);
    assign cfault = mask_fault(
        state_reg.in_q[PB_N+SW_N+RDR_ILK_N +: CTL_ILK_N], cbyp, maint);
    assign dc_ok = state_reg.in_q[PB_N+SW_N+RDR_ILK_N+CTL_ILK_N +: DC_N];
    assign any_fault = |{rfault, cfault};

    always_comb begin
        state_next = state_reg;
        // Change counts once second and third stages agree
        state_next.s1 = raw_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        for (int i = 0; i < IN_N; i++) begin
            if (state_reg.s2[i] == state_reg.s3[i]) begin
                state_next.in_q[i] = state_reg.s3[i];
            end
        end
        // Debounce: level must hold for the whole window
        pb_rise = '0;
        for (int i = 0; i < PB_N; i++) begin
            if (pb_in[i] == state_reg.pb_stable[i]) begin
                state_next.pb_cnt[i] = DB_ZERO;
            end else if (state_reg.pb_cnt[i] == DB_LAST) begin
                state_next.pb_cnt[i] = DB_ZERO;
                state_next.pb_stable[i] = pb_in[i];
                pb_rise[i] = pb_in[i];
            end else begin
                state_next.pb_cnt[i] = state_reg.pb_cnt[i] + 1'b1;
            end
        end
        if (pb_rise[PB_JOURNAL]) begin
            state_next.journal_on = ~state_reg.journal_on;
        end
        state_next.stop_out = state_reg.pb_stable[PB_STOP];
        state_next.param_out = state_reg.pb_stable[PB_PARAM];
        // Power control
        case (state_reg.pwr)
            OPL_PWR_OFF: begin
                if (pb_rise[PB_POWER] && pwr_en && ctl_pwr && !any_fault) begin
                    state_next.pwr = OPL_PWR_ON;
                end
            end
            OPL_PWR_ON: begin
                if (any_fault) begin
                    state_next.pwr = OPL_PWR_TRIP;
                end else if (!pwr_en || !ctl_pwr) begin
                    state_next.pwr = OPL_PWR_OFF;
                end else if (pb_rise[PB_POWER]) begin
                    state_next.pwr = OPL_PWR_OFF;
                end
            end
            OPL_PWR_TRIP: begin
                // Trip holds until a maintenance fault reset
                if (maint && state_reg.in_q[PB_N+3] && !any_fault) begin
                    state_next.pwr = OPL_PWR_OFF;
                end
            end
            default: state_next.pwr = OPL_PWR_OFF;
        endcase
        // Failure lamps latch; set wins over reset
        if (maint && state_reg.in_q[PB_N+3]) begin
            state_next.rdr_fail = '0;
            state_next.ctl_fail = '0;
        end
        if (pwr_en) begin
            state_next.rdr_fail = state_next.rdr_fail | rfault;
            state_next.ctl_fail = state_next.ctl_fail | cfault;
        end
        state_next.probe = {sync_src[link.sync_sel_b],
            sync_src[link.sync_sel_a]};
        state_next.freeze = freeze_pos ? link.freeze_req : '0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.stop_req = state_reg.stop_out;
    assign link.param_req = state_reg.param_out;
    assign journal_enable = state_reg.journal_on;
    assign journal_lamp = state_reg.journal_on;
    assign reader_ac_on = (state_reg.pwr == OPL_PWR_ON);
    assign system_power_on = (state_reg.pwr == OPL_PWR_ON);
    assign reader_power_lamp = (state_reg.pwr == OPL_PWR_ON) && (&dc_ok);
    assign rdr_bypass_lamp = rbyp;
    assign ctl_bypass_lamp = cbyp;
    assign rdr_fail_lamp = state_reg.rdr_fail;
    assign ctl_fail_lamp = state_reg.ctl_fail;
    assign selectable_sync_probe = state_reg.probe;
    assign phase_freeze = state_reg.freeze;
endmodule // opl_reader

// *** core/opl_pkg.sv ***
/*
 Package for the operator panel and interlock logic: widths, counts,
 state codes and field positions shared by both ends.
 Assumes a single 250 MHz clock on both ends.
*/
package opl_pkg;
    localparam int CLK_MHZ = 250;
    // Debounce time in microseconds, rounded down to cycles
    localparam int DEBOUNCE_US = 2;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
    localparam int DB_W = 10;
    localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC - 1);
    localparam logic [DB_W-1:0] DB_ZERO = 10'h000;
    // Interlock sensor, bypass and DC supply counts
    localparam int RDR_ILK_N = 4;
    localparam int CTL_ILK_N = 4;
    localparam int DC_N = 4;
    // Timing phase and sync source widths
    localparam int PHASE_N = 8;
    localparam int SYNC_SEL_W = 3;
    localparam int SYNC_SRC_N = 8;
    localparam logic [SYNC_SEL_W-1:0] SYNC_SEL_RST = 3'h0;
    // Pushbutton indices
    localparam int PB_STOP = 0;
    localparam int PB_PARAM = 1;
    localparam int PB_JOURNAL = 2;
    localparam int PB_POWER = 3;
    localparam int PB_N = 4;
    typedef enum logic [1:0] {
        OPL_PWR_OFF = 2'b00,
        OPL_PWR_ON = 2'b01,
        OPL_PWR_TRIP = 2'b10
    } opl_pwr_t;
    typedef enum logic [1:0] {
        OPL_CTL_ONLINE = 2'b00,
        OPL_CTL_PARAM = 2'b01,
        OPL_CTL_STOPPED = 2'b10
    } opl_ctl_t;
endpackage

// *** core/opl_link_if.sv ***
/*
 Interface joining the reader panel end and the reader controller end.
 Assumes both ends share clk; all signals are plain levels.
*/
`timescale 1ns/1ps
interface opl_link_if;
    import opl_pkg::*;
    logic stop_req;
    logic param_req;
    logic stop_lamp;
    logic param_lamp;
    logic [SYNC_SEL_W-1:0] sync_sel_a;
    logic [SYNC_SEL_W-1:0] sync_sel_b;
    logic [PHASE_N-1:0] freeze_req;
    modport reader (
        output stop_req, output param_req,
        input stop_lamp, input param_lamp,
        input sync_sel_a, input sync_sel_b, input freeze_req
    );
    modport controller (
        input stop_req, input param_req,
        output stop_lamp, output param_lamp,
        output sync_sel_a, output sync_sel_b, output freeze_req
    );
endinterface

// *** core/opl_controller.sv ***
/*
 Controller end of the panel link: stop lamp, parameter entry state
 and lamp, sync probe selection and timing freeze requests.
 Assumes link inputs come from the reader end on the same clk.
*/
`timescale 1ns/1ps
module opl_controller
    import opl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Reader link
    opl_link_if.controller link,
    // Controller side
    input wire logic reader_ready,
    input wire logic param_done,
    input wire logic [SYNC_SEL_W-1:0] sync_sel_a_in,
    input wire logic [SYNC_SEL_W-1:0] sync_sel_b_in,
    input wire logic [PHASE_N-1:0] freeze_in,
    output logic reader_not_ready,
    output logic param_only,
    output logic off_line
);
    typedef struct packed {
        opl_ctl_t st;
        logic stop_lamp;
        logic param_lamp;
        logic [SYNC_SEL_W-1:0] sel_a;
        logic [SYNC_SEL_W-1:0] sel_b;
        logic [PHASE_N-1:0] freeze;
    } opl_ctl_state_t;

    opl_ctl_state_t state_reg;
    opl_ctl_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg.st)
            OPL_CTL_ONLINE: begin
                if (link.param_req) begin
                    state_next.st = OPL_CTL_PARAM;
                end else if (link.stop_req || !reader_ready) begin
                    state_next.st = OPL_CTL_STOPPED;
                end
            end
            OPL_CTL_PARAM: begin
                // Held until software finishes parameters
                if (param_done) begin
                    state_next.st = OPL_CTL_STOPPED;
                end
            end
            OPL_CTL_STOPPED: begin
                if (link.param_req) begin
                    state_next.st = OPL_CTL_PARAM;
                end else if (!link.stop_req && reader_ready) begin
                    state_next.st = OPL_CTL_ONLINE;
                end
            end
            default: state_next.st = OPL_CTL_STOPPED;
        endcase
        state_next.stop_lamp = link.stop_req || !reader_ready;
        state_next.param_lamp = link.param_req
            && (state_reg.st == OPL_CTL_PARAM);
        state_next.sel_a = sync_sel_a_in;
        state_next.sel_b = sync_sel_b_in;
        state_next.freeze = freeze_in;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '{st: OPL_CTL_STOPPED, stop_lamp: 1'b1,
                param_lamp: 1'b0, sel_a: SYNC_SEL_RST, sel_b: SYNC_SEL_RST,
                freeze: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.stop_lamp = state_reg.stop_lamp;
    assign link.param_lamp = state_reg.param_lamp;
    assign link.sync_sel_a = state_reg.sel_a;
    assign link.sync_sel_b = state_reg.sel_b;
    assign link.freeze_req = state_reg.freeze;
    assign reader_not_ready = state_reg.stop_lamp;
    assign off_line = state_reg.stop_lamp;
    assign param_only = (state_reg.st == OPL_CTL_PARAM);
endmodule // opl_controller

// *** tb/opl_link_asserts.sv ***
/*
 Checker for the panel link between reader end and controller end.
 Assumes it is instantiated beside the link interface, one clock.
*/
`timescale 1ns/1ps
module opl_link_asserts
    import opl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Link levels
    input wire logic stop_req,
    input wire logic param_req,
    input wire logic stop_lamp,
    input wire logic param_lamp,
    input wire logic [SYNC_SEL_W-1:0] sync_sel_a,
    input wire logic [SYNC_SEL_W-1:0] sync_sel_b,
    input wire logic [PHASE_N-1:0] freeze_req
);
    localparam int GAP_MIN = DEBOUNCE_CYC - 1;
    logic [DB_W:0] stop_gap;
    logic [DB_W:0] param_gap;
    // Saturating, so long idle spells never wrap
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stop_gap <= '0;
            param_gap <= '0;
        end else begin
            stop_gap <= (stop_req != $past(stop_req)) ? '0 :
                (&stop_gap ? stop_gap : stop_gap + 1'b1);
            param_gap <= (param_req != $past(param_req)) ? '0 :
                (&param_gap ? param_gap : param_gap + 1'b1);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence param_press_s;
        $rose(param_req);
    endsequence
    sequence param_lit_s;
        ##[1:3] param_lamp;
    endsequence
    stop_lamp_follow_a: assert property (stop_req |=> stop_lamp)
        else $error("stop lamp missed a stop request");
    stop_lamp_fall_a: assert property (
        $fell(stop_lamp) |-> !$past(stop_req))
        else $error("stop lamp dropped while stop was requested");
    param_lamp_cause_a: assert property (
        param_lamp |-> $past(param_req))
        else $error("parameter lamp lit without a request");
    param_lamp_rise_a: assert property (
        param_press_s |-> param_lit_s)
        else $error("parameter state not entered after request");
    param_lamp_drop_a: assert property (
        !param_req |=> !param_lamp)
        else $error("parameter lamp stayed lit after release");
    stop_gap_min_a: assert property (
        $changed(stop_req) |-> stop_gap >= GAP_MIN)
        else $error("stop request changed faster than debounce");
    param_gap_min_a: assert property (
        $changed(param_req) |-> param_gap >= GAP_MIN)
        else $error("parameter request changed faster than debounce");
    reset_state_a: assert property (disable iff (1'b0)
        !nrst |-> stop_lamp && !param_lamp && !stop_req && !param_req)
        else $error("link levels wrong during reset");
    reset_select_a: assert property (disable iff (1'b0)
        !nrst |-> sync_sel_a == SYNC_SEL_RST && sync_sel_b == SYNC_SEL_RST
            && freeze_req == '0)
        else $error("select levels wrong during reset");
endmodule // opl_link_asserts

// *** tb/operator_panel_interlock_logic_tb_top.sv ***
/*
 Testbench joining reader end and controller end over the link.
 Assumes the 500-cycle debounce of the package; no other clocks.
*/
`timescale 1ns/1ps
module operator_panel_interlock_logic_tb_top import opl_pkg::*; ();
    logic clk, nrst, pwr_en, ctl_pwr, maint, freset, tfp, ready, pdone;
    logic [PB_N-1:0] button_raw;
    logic [3:0] rbyp, cbyp, rflt, cflt, dc_ok, rbl, cbl, rfl, cfl;
    logic [7:0] src, freeze_in, pfz;
    logic [2:0] sel_a, sel_b;
    logic j_lamp, j_en, ac_on, p_lamp, sys_on, rnr, ponly, offl;
    logic [1:0] probe;
    int err_total, checked;
    opl_link_if opl_link_if_inst ();
    opl_reader opl_reader_inst (.clk(clk), .nrst(nrst),
        .link(opl_link_if_inst), .button_raw(button_raw),
        .power_enable_sw(pwr_en), .controller_power_sw(ctl_pwr),
        .maintenance_sw(maint), .fault_reset_sw(freset),
        .timing_freeze_position(tfp), .rdr_bypass_sw(rbyp),
        .ctl_bypass_sw(cbyp), .rdr_fault_raw(rflt), .ctl_fault_raw(cflt),
        .dc_ok_raw(dc_ok), .sync_src(src), .journal_lamp(j_lamp),
        .journal_enable(j_en), .reader_ac_on(ac_on),
        .reader_power_lamp(p_lamp), .system_power_on(sys_on),
        .rdr_bypass_lamp(rbl), .ctl_bypass_lamp(cbl), .rdr_fail_lamp(rfl),
        .ctl_fail_lamp(cfl), .selectable_sync_probe(probe),
        .phase_freeze(pfz));
    opl_controller opl_controller_inst (.clk(clk), .nrst(nrst),
        .link(opl_link_if_inst), .reader_ready(ready), .param_done(pdone),
        .sync_sel_a_in(sel_a), .sync_sel_b_in(sel_b), .freeze_in(freeze_in),
        .reader_not_ready(rnr), .param_only(ponly), .off_line(offl));
    opl_link_asserts opl_link_asserts_inst (.clk(clk), .nrst(nrst),
        .stop_req(opl_link_if_inst.stop_req),
        .param_req(opl_link_if_inst.param_req),
        .stop_lamp(opl_link_if_inst.stop_lamp),
        .param_lamp(opl_link_if_inst.param_lamp),
        .sync_sel_a(opl_link_if_inst.sync_sel_a),
        .sync_sel_b(opl_link_if_inst.sync_sel_b),
        .freeze_req(opl_link_if_inst.freeze_req));
    always #2 clk = ~clk;
    task chk(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task summarize;
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Held past the debounce window, then released just as long
    task press(input int idx);
        button_raw[idx] = 1'b1;
        hold(520);
        button_raw[idx] = 1'b0;
        hold(520);
    endtask
    task wait_stop(input logic lvl);
        for (int i = 0; i < 700 && opl_link_if_inst.stop_req !== lvl; i++)
            @(negedge clk);
        if (opl_link_if_inst.stop_req !== lvl) begin
            chk("stop_req", opl_link_if_inst.stop_req, lvl);
            summarize();
        end
    endtask
    initial begin
        {clk, nrst, button_raw, src, freeze_in, sel_a, sel_b} = '0;
        {pwr_en, ctl_pwr, maint, freset, tfp, ready, pdone} = '0;
        {rbyp, cbyp, rflt, cflt} = '0;
        dc_ok = 4'hF;
        err_total = 0;
        checked = 0;
        nrst = 1'b1;
        #1 nrst = 1'b0;
        hold(10);
        nrst = 1'b1;
        hold(2);
        chk("stop_lamp", opl_link_if_inst.stop_lamp, 8'h01);
        chk("off_line", offl, 8'h01);
        ready = 1'b1;
        hold(3);
        chk("not_ready", rnr, 8'h00);
        button_raw[PB_STOP] = 1'b1;
        wait_stop(1'b1);
        hold(2);
        chk("stop_lamp", opl_link_if_inst.stop_lamp, 8'h01);
        chk("not_ready", {offl, rnr}, 8'h03);
        button_raw[PB_STOP] = 1'b0;
        wait_stop(1'b0);
        hold(2);
        chk("stop_lamp", opl_link_if_inst.stop_lamp, 8'h00);
        button_raw[PB_PARAM] = 1'b1;
        hold(520);
        chk("param_lamp", opl_link_if_inst.param_lamp, 8'h01);
        chk("param_only", ponly, 8'h01);
        button_raw[PB_PARAM] = 1'b0;
        hold(520);
        chk("param_lamp", opl_link_if_inst.param_lamp, 8'h00);
        chk("param_only", ponly, 8'h01);
        pdone = 1'b1;
        hold(2);
        pdone = 1'b0;
        hold(2);
        chk("param_only", ponly, 8'h00);
        // A bounce shorter than the window must not toggle
        button_raw[PB_JOURNAL] = 1'b1;
        hold(100);
        button_raw[PB_JOURNAL] = 1'b0;
        hold(100);
        chk("journal", j_en, 8'h00);
        press(PB_JOURNAL);
        chk("journal", {j_lamp, j_en}, 8'h03);
        press(PB_JOURNAL);
        chk("journal", {j_lamp, j_en}, 8'h00);
        press(PB_POWER);
        chk("ac_on", ac_on, 8'h00);
        {pwr_en, ctl_pwr} = 2'b11;
        hold(5);
        press(PB_POWER);
        chk("power", {ac_on, sys_on, p_lamp}, 8'h07);
        dc_ok = 4'hE;
        hold(5);
        chk("power_lamp", p_lamp, 8'h00);
        dc_ok = 4'hF;
        {rbyp, rflt} = 8'h22;
        hold(5);
        chk("bypass_lamp", rbl, 8'h02);
        chk("sys_on", sys_on, 8'h00);
        rflt = 4'h0;
        hold(5);
        chk("fail_lamp", rfl, 8'h02);
        {maint, freset} = 2'b11;
        hold(5);
        freset = 1'b0;
        hold(5);
        chk("fail_lamp", rfl, 8'h00);
        press(PB_POWER);
        chk("sys_on", sys_on, 8'h01);
        {rbyp, rflt, cbyp, cflt} = 16'h4411;
        hold(5);
        chk("masked_power", sys_on, 8'h01);
        chk("masked_lamps", {rfl, cfl}, 8'h00);
        chk("ctl_bypass_lamp", cbl, 8'h01);
        maint = 1'b0;
        hold(5);
        chk("normal_trip", sys_on, 8'h00);
        chk("normal_lamps", {rfl, cfl}, 8'h41);
        {rflt, cflt} = '0;
        {sel_a, sel_b, src} = {3'h3, 3'h5, 8'h28};
        hold(5);
        chk("probe", probe, 8'h03);
        src = 8'h08;
        hold(5);
        chk("probe", probe, 8'h01);
        chk("sel_b", opl_link_if_inst.sync_sel_b, 8'h05);
        freeze_in = 8'hA5;
        hold(5);
        chk("freeze", pfz, 8'h00);
        tfp = 1'b1;
        hold(5);
        chk("freeze", pfz, 8'hA5);
        nrst = 1'b0;
        hold(2);
        // Reset value only shows while reset is held; ready clears it after
        chk("stop_lamp", opl_link_if_inst.stop_lamp, 8'h01);
        chk("off_line", offl, 8'h01);
        chk("freeze", pfz, 8'h00);
        nrst = 1'b1;
        hold(2);
        chk("stop_lamp", opl_link_if_inst.stop_lamp, 8'h00);
        summarize();
    end
endmodule // operator_panel_interlock_logic_tb_top
